/* File: rtl/sfpe_cfg.svh */
`ifndef SFPE_CFG_SVH
`define SFPE_CFG_SVH

// opcodes decoded by the sequencer
`define SFPE_OP_UNLOCK 8'h06
`define SFPE_OP_PAGE 8'h02
`define SFPE_OP_QPAGE 8'h32
`define SFPE_OP_SECT 8'h20
`define SFPE_OP_BLK32 8'h52
`define SFPE_OP_BLK64 8'hd8
`define SFPE_OP_CHIP_A 8'h60
`define SFPE_OP_CHIP_B 8'hc7
`define SFPE_OP_RDPARM 8'hc0

// frame lengths in whole bytes, including the opcode
`define SFPE_LEN_OPC 10'h001
`define SFPE_LEN_PARM 10'h002
`define SFPE_LEN_ADDR 10'h004
`define SFPE_LEN_DATA1 10'h005
`define SFPE_LEN_SAT 10'h3ff

// read parameter byte fields and reset values
`define SFPE_DUMMY_MSB 5
`define SFPE_DUMMY_LSB 4
`define SFPE_WRAP_MSB 1
`define SFPE_WRAP_LSB 0
`define SFPE_DUMMY_LO 4'h4
`define SFPE_DUMMY_MID 4'h6
`define SFPE_DUMMY_HI 4'h8
`define SFPE_WRAP_BASE 7'h08

// geometry as address masks
`define SFPE_MASK_PAGE 23'h0000ff
`define SFPE_MASK_SECT 23'h000fff
`define SFPE_MASK_BLK32 23'h007fff
`define SFPE_MASK_BLK64 23'h00ffff

// protect region sizes as log2 of bytes
`define SFPE_PROT_BLK_BASE 5'h10
`define SFPE_PROT_SECT_BASE 5'h0c
`define SFPE_PROT_SECT_MAX 3'h3

// self-timed durations
`define SFPE_CLK_MHZ 200
`define SFPE_TPP_US 500
`define SFPE_TSE_US 50000
`define SFPE_TBE1_US 200000
`define SFPE_TBE2_US 300000
`define SFPE_TCE_US 20000000

`endif

/* File: rtl/sfpe_pkg.sv */
package sfpe_pkg;

    // array operation handed to the cell array
    typedef enum logic [2:0] {SFPE_NONE, SFPE_PAGE, SFPE_SECT, SFPE_BLK32, SFPE_BLK64, SFPE_CHIP} sfpe_op_t;

    typedef enum logic [0:0] {SFPE_IDLE, SFPE_BUSY} sfpe_st_t;

    typedef struct packed {
        sfpe_op_t op;
        logic [23:0] addr;
    } sfpe_arr_cmd_t;

    typedef struct packed {
        logic [4:0] bp;
        logic cmp;
    } sfpe_prot_t;

    typedef struct packed {
        logic [3:0] dummy;
        logic [6:0] wrap_bytes;
    } sfpe_rdparm_t;

    // link-side frame capture
    typedef struct packed {
        logic tog;
        logic quad;
        logic [2:0] bitc;
        logic [9:0] bytec;
        logic [7:0] sh;
        logic [7:0] opc;
        logic [23:0] addr;
        logic [7:0] parm;
        logic [7:0] widx;
        logic [255:0] keep;
    } sfpe_link_t;

    typedef struct packed {
        logic [2:0] cs_s;
        logic cs_hi;
        logic [1:0] tog_s;
        logic tog_seen;
        sfpe_st_t st;
        logic latch;
        sfpe_rdparm_t rp;
        sfpe_arr_cmd_t cmd;
        logic go;
        logic tload;
        logic [31:0] tcnt;
        logic [7:0] pg_data;
        logic pg_keep;
    } sfpe_core_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic busy;
        logic done;
    } sfpe_tmr_t;

endpackage : sfpe_pkg

/* File: rtl/sfpe_timer.sv */
`timescale 1ns/1ps
`include "sfpe_cfg.svh"

module sfpe_timer import sfpe_pkg::*; (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // load
    input wire logic load_i,
    input wire logic [31:0] count_i,
    // status
    output logic busy_o,
    output logic done_o
);

    sfpe_tmr_t tm_q;
    sfpe_tmr_t tm_d;

    // down counter; a zero count still runs one cycle so busy never skips
    always_comb begin
        tm_d = tm_q;
        tm_d.done = 1'b0;
        if (load_i) begin
            tm_d.cnt = (count_i == 32'h0) ? 32'h1 : count_i;
            tm_d.busy = 1'b1;
        end else if (tm_q.busy) begin
            if (tm_q.cnt <= 32'h1) begin
                tm_d.busy = 1'b0;
                tm_d.done = 1'b1;
            end else begin
                tm_d.cnt = tm_q.cnt - 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tm_q <= '0;
        end else if (ce_i) begin
            tm_q <= tm_d;
        end
    end

    assign busy_o = tm_q.busy;
    assign done_o = tm_q.done;

endmodule : sfpe_timer

/* File: rtl/sfpe_flash_seq.sv */
// What this block does
// - busy flag high through whole self-timed cycle
// - write latch cleared during every cycle
// - no page program into protected page
// - four-lane program needs four-lane enable bit
// - four-lane program: opcode, then address and data on four lanes
// - over 256 bytes: keep last 256 only
// - short program leaves other page bytes alone
// - four-lane program needs select on byte boundary
// - four-lane program timed by page duration
// - sector erase wipes sector holding address
// - sector and block erase run only if select rises after address
// - opcode 52H wipes 32KB block, own duration
// - opcode D8H wipes 64KB block, own duration
// - refuse sector erase in protected region
// - refuse block erase in protected region
// - 60H or C7H whole-chip erase, opcode only
// - chip erase only if bp[2:0] is 0 without complement, or 7 with complement
// - four-lane mode parameter sets dummy clocks
// - parameter low field sets wrap length
// - wrap setting survives switch to four-lane mode
// - program data wraps within current page
`timescale 1ns/1ps
`include "sfpe_cfg.svh"

module sfpe_flash_seq import sfpe_pkg::*; #(
    parameter logic [31:0] TPP_CYC = 32'(64'(`SFPE_TPP_US) * 64'(`SFPE_CLK_MHZ)),
    parameter logic [31:0] TSE_CYC = 32'(64'(`SFPE_TSE_US) * 64'(`SFPE_CLK_MHZ)),
    parameter logic [31:0] TBE1_CYC = 32'(64'(`SFPE_TBE1_US) * 64'(`SFPE_CLK_MHZ)),
    parameter logic [31:0] TBE2_CYC = 32'(64'(`SFPE_TBE2_US) * 64'(`SFPE_CLK_MHZ)),
    parameter logic [31:0] TCE_CYC = 32'(64'(`SFPE_TCE_US) * 64'(`SFPE_CLK_MHZ))
) (
    // core clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // serial link from the host controller
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic [3:0] io_i,
    // configuration bits from the status register
    input wire logic four_lane_cmd_mode_i,
    input wire logic four_lane_enable_i,
    input wire sfpe_prot_t prot_i,
    // status
    output logic op_in_progress_o,
    output logic write_latch_o,
    output sfpe_rdparm_t rdparm_o,
    // cell array command and page buffer read port
    output logic arr_go_o,
    output sfpe_arr_cmd_t arr_cmd_o,
    input wire logic [7:0] pg_idx_i,
    output logic [7:0] pg_data_o,
    output logic pg_keep_o
);

    // is address a inside the guarded region (complement applied)
    function automatic logic sfpe_hit(input logic [22:0] a, input sfpe_prot_t p);
        logic [4:0] s;
        logic in_r;
        if (p.bp[4]) begin
            s = `SFPE_PROT_SECT_BASE + 5'((p.bp[2:0] > 3'h4) ? `SFPE_PROT_SECT_MAX : (p.bp[2:0] - 3'h1));
        end else begin
            s = `SFPE_PROT_BLK_BASE + 5'(p.bp[2:0] - 3'h1);
        end
        if (p.bp[2:0] == 3'h0) begin
            in_r = 1'b0;
        end else if (p.bp[2:0] == 3'h7 && !p.bp[4]) begin
            in_r = 1'b1;
        end else if (p.bp[3]) begin
            in_r = ((a >> s) == 23'h0);
        end else begin
            in_r = ((~a >> s) == 23'h0);
        end
        return in_r ^ p.cmp;
    endfunction : sfpe_hit

    // region is a prefix or suffix, so checking both ends of the span is enough
    function automatic logic sfpe_span_prot(input logic [22:0] a, input logic [22:0] m,
                                            input sfpe_prot_t p);
        return sfpe_hit(a & ~m, p) | sfpe_hit(a | m, p);
    endfunction : sfpe_span_prot

    // ------------------------------------------------------------------
    // link domain: runs only on host clock edges inside a frame
    // ------------------------------------------------------------------
    sfpe_link_t ln_q;
    sfpe_link_t ln_d;
    sfpe_link_t lb;
    logic lk_started_q;
    logic lk_frame_rst_b;
    logic [3:0] lk_sum;
    logic [7:0] lk_sh;
    logic lk_done;
    logic lk_wr;
    logic [7:0] pg_mem [256];

    // select high clears only the frame-start flag, so captured fields stay readable
    assign lk_frame_rst_b = rst_b_i & ~cs_b_i;

    always_ff @(posedge sclk_i or negedge lk_frame_rst_b) begin
        if (!lk_frame_rst_b) begin
            lk_started_q <= 1'b0;
        end else begin
            lk_started_q <= 1'b1;
        end
    end

    // shift lanes in; mode is sampled once on the first edge of a frame
    always_comb begin
        lb = ln_q;
        if (!lk_started_q) begin
            lb.tog = ~ln_q.tog;
            lb.quad = four_lane_cmd_mode_i;
            lb.bitc = 3'h0;
            lb.bytec = 10'h000;
            lb.sh = 8'h00;
            lb.keep = '0;
        end
        lk_sum = {1'b0, lb.bitc} + (lb.quad ? 4'h4 : 4'h1);
        lk_sh = lb.quad ? {lb.sh[3:0], io_i} : {lb.sh[6:0], io_i[0]};
        lk_done = lk_sum[3];
        lk_wr = 1'b0;
        ln_d = lb;
        ln_d.sh = lk_sh;
        ln_d.bitc = lk_sum[2:0];
        if (lk_done) begin
            if (lb.bytec != `SFPE_LEN_SAT) begin
                ln_d.bytec = lb.bytec + 10'h001;
            end
            if (lb.bytec == 10'h000) begin
                ln_d.opc = lk_sh;
                if (lk_sh == `SFPE_OP_QPAGE) begin
                    ln_d.quad = 1'b1; // address and data follow on all lanes
                end
            end else if (lb.bytec < `SFPE_LEN_ADDR) begin
                ln_d.addr = {lb.addr[15:0], lk_sh};
                if (lb.bytec == 10'h001) begin
                    ln_d.parm = lk_sh;
                end
                ln_d.widx = lk_sh; // last address byte seeds the page index
            end else begin
                lk_wr = 1'b1;
                ln_d.keep[lb.widx] = 1'b1; // untouched bytes stay unmarked
                ln_d.widx = lb.widx + 8'h01; // wraps to byte 0 of the page
            end
        end
    end

    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ln_q <= '0;
        end else begin
            ln_q <= ln_d;
        end
    end

    // page buffer; a long burst overwrites older bytes in place
    always_ff @(posedge sclk_i) begin
        if (lk_wr) begin
            pg_mem[lb.widx] <= lk_sh;
        end
    end

    // ------------------------------------------------------------------
    // core domain: frame decode and self-timed cycle
    // ------------------------------------------------------------------
    sfpe_core_t cr_q;
    sfpe_core_t cr_d;
    logic cs_rise;
    logic fresh;
    logic on_byte;
    logic accept;
    logic [9:0] nbytes;
    logic [7:0] opc;
    logic [22:0] a23;
    logic tmr_busy;
    logic tmr_done;
    sfpe_arr_cmd_t cand;
    logic [31:0] cand_cnt;

    // link fields are quasi-static once select is high, so they are read directly
    assign opc = ln_q.opc;
    assign nbytes = ln_q.bytec;
    assign a23 = ln_q.addr[22:0];
    assign on_byte = (ln_q.bitc == 3'h0);

    // frame classification into a candidate array operation
    always_comb begin
        cand.op = SFPE_NONE;
        cand.addr = ln_q.addr;
        cand_cnt = TPP_CYC;
        case (opc)
            `SFPE_OP_PAGE: begin
                if (nbytes >= `SFPE_LEN_DATA1 && on_byte &&
                    !sfpe_span_prot(a23, `SFPE_MASK_PAGE, prot_i)) begin
                    cand.op = SFPE_PAGE;
                end
            end
            `SFPE_OP_QPAGE: begin
                if (nbytes >= `SFPE_LEN_DATA1 && on_byte &&
                    four_lane_enable_i &&
                    !sfpe_span_prot(a23, `SFPE_MASK_PAGE, prot_i)) begin
                    cand.op = SFPE_PAGE;
                end
            end
            `SFPE_OP_SECT: begin
                if (nbytes == `SFPE_LEN_ADDR && on_byte &&
                    !sfpe_span_prot(a23, `SFPE_MASK_SECT, prot_i)) begin
                    cand.op = SFPE_SECT;
                    cand.addr = {1'b0, a23 & ~`SFPE_MASK_SECT}; // any address in sector
                    cand_cnt = TSE_CYC;
                end
            end
            `SFPE_OP_BLK32: begin
                if (nbytes == `SFPE_LEN_ADDR && on_byte &&
                    !sfpe_span_prot(a23, `SFPE_MASK_BLK32, prot_i)) begin
                    cand.op = SFPE_BLK32;
                    cand.addr = {1'b0, a23 & ~`SFPE_MASK_BLK32};
                    cand_cnt = TBE1_CYC;
                end
            end
            `SFPE_OP_BLK64: begin
                if (nbytes == `SFPE_LEN_ADDR && on_byte &&
                    !sfpe_span_prot(a23, `SFPE_MASK_BLK64, prot_i)) begin
                    cand.op = SFPE_BLK64;
                    cand.addr = {1'b0, a23 & ~`SFPE_MASK_BLK64};
                    cand_cnt = TBE2_CYC;
                end
            end
            `SFPE_OP_CHIP_A, `SFPE_OP_CHIP_B: begin
                // whole chip only when bp[2:0] is 0 without complement, or 7 with complement (bp[4] not checked)
                if (nbytes == `SFPE_LEN_OPC && on_byte &&
                    (prot_i.cmp ? (prot_i.bp[2:0] == 3'h7) : (prot_i.bp[2:0] == 3'h0))) begin
                    cand.op = SFPE_CHIP;
                    cand.addr = 24'h000000;
                    cand_cnt = TCE_CYC;
                end
            end
            default: begin
                cand.op = SFPE_NONE;
            end
        endcase
    end

    // three-stage select sync: a change counts once stages two and three agree
    assign cs_rise = !cr_q.cs_hi && (cr_q.cs_s[1] == cr_q.cs_s[2]) && cr_q.cs_s[2];
    assign fresh = (cr_q.tog_s[1] != cr_q.tog_seen);
    // without the write latch the frame starts no cycle; its data still reaches the page buffer
    assign accept = cs_rise && fresh && (cr_q.st == SFPE_IDLE) && cr_q.latch && (cand.op != SFPE_NONE);

    always_comb begin
        cr_d = cr_q;
        cr_d.go = 1'b0;
        cr_d.tload = 1'b0;
        cr_d.cs_s = {cr_q.cs_s[1:0], cs_b_i};
        if (cr_q.cs_s[1] == cr_q.cs_s[2]) begin
            cr_d.cs_hi = cr_q.cs_s[2];
        end
        cr_d.tog_s = {cr_q.tog_s[0], ln_q.tog};
        if (cs_rise) begin
            cr_d.tog_seen = cr_q.tog_s[1];
        end
        // page buffer read port, registered; valid while a cycle runs
        cr_d.pg_data = pg_mem[pg_idx_i];
        cr_d.pg_keep = ln_q.keep[pg_idx_i];
        case (cr_q.st)
            SFPE_IDLE: begin
                if (cs_rise && fresh && on_byte) begin
                    if (opc == `SFPE_OP_UNLOCK && nbytes == `SFPE_LEN_OPC) begin
                        cr_d.latch = 1'b1; // host unlock precedes program/erase
                    end
                    if (opc == `SFPE_OP_RDPARM && nbytes == `SFPE_LEN_PARM && four_lane_cmd_mode_i) begin
                        case (ln_q.parm[`SFPE_DUMMY_MSB:`SFPE_DUMMY_LSB])
                            2'h2: cr_d.rp.dummy = `SFPE_DUMMY_MID;
                            2'h3: cr_d.rp.dummy = `SFPE_DUMMY_HI;
                            default: cr_d.rp.dummy = `SFPE_DUMMY_LO;
                        endcase
                        // 8, 16, 32 or 64 bytes
                        cr_d.rp.wrap_bytes = `SFPE_WRAP_BASE << ln_q.parm[`SFPE_WRAP_MSB:`SFPE_WRAP_LSB];
                    end
                end
                if (accept) begin
                    // cycle starts on select rising
                    cr_d.st = SFPE_BUSY;
                    cr_d.cmd = cand;
                    cr_d.go = 1'b1;
                    cr_d.tload = 1'b1;
                    cr_d.tcnt = cand_cnt;
                    cr_d.latch = 1'b0; // latch drops at cycle start
                end
            end
            SFPE_BUSY: begin
                if (tmr_done) begin
                    cr_d.st = SFPE_IDLE; // busy flag falls when timer ends
                end
            end
            default: begin
                cr_d.st = SFPE_IDLE;
            end
        endcase
    end

    // wrap length only changes on a parameter frame, never on mode switch
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cr_q <= '0;
            cr_q.cs_s <= 3'h7;
            cr_q.cs_hi <= 1'b1;
            cr_q.st <= SFPE_IDLE;
            cr_q.rp <= {`SFPE_DUMMY_LO, `SFPE_WRAP_BASE};
        end else if (ce_i) begin
            cr_q <= cr_d;
        end
    end

    // self-timed duration counter
    sfpe_timer u_timer (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .load_i(cr_q.tload),
        .count_i(cr_q.tcnt),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    // outputs straight from state flops
    assign op_in_progress_o = (cr_q.st == SFPE_BUSY);
    assign write_latch_o = cr_q.latch;
    assign rdparm_o = cr_q.rp;
    assign arr_go_o = cr_q.go;
    assign arr_cmd_o = cr_q.cmd;
    assign pg_data_o = cr_q.pg_data;
    assign pg_keep_o = cr_q.pg_keep;

endmodule : sfpe_flash_seq

/* File: tb/sfpe_seq_chk_sva.sv */
`timescale 1ns/1ps
module sfpe_seq_chk import sfpe_pkg::*; #(
    parameter logic [31:0] TPP_CYC = 32'h14,
    parameter logic [31:0] TSE_CYC = 32'h14,
    parameter logic [31:0] TBE1_CYC = 32'h14,
    parameter logic [31:0] TBE2_CYC = 32'h14,
    parameter logic [31:0] TCE_CYC = 32'h14
) (
    // core side
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // link and configuration
    input wire logic cs_b_i,
    input wire sfpe_prot_t prot_i,
    // status and array command
    input wire logic op_in_progress_o,
    input wire logic write_latch_o,
    input wire sfpe_rdparm_t rdparm_o,
    input wire logic arr_go_o,
    input wire sfpe_arr_cmd_t arr_cmd_o
);
    logic [31:0] busy_cnt_q;
    logic [31:0] want;
    // cycles the busy flag has stood; frozen with the core enable
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= op_in_progress_o ? busy_cnt_q + {31'h0, ce_i} : 32'h0;
        end
    end
    // length per operation, two cycles of start and finish overhead
    always_comb begin
        case (arr_cmd_o.op)
            SFPE_PAGE: want = TPP_CYC + 32'h2;
            SFPE_SECT: want = TSE_CYC + 32'h2;
            SFPE_BLK32: want = TBE1_CYC + 32'h2;
            SFPE_BLK64: want = TBE2_CYC + 32'h2;
            default: want = TCE_CYC + 32'h2;
        endcase
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_start;
        arr_go_o && op_in_progress_o && !write_latch_o;
    endsequence
    sequence s_run;
        !arr_go_o && op_in_progress_o;
    endsequence
    start_flags_a: assert property (arr_go_o |-> s_start ##1 s_run)
        else $error("start of cycle flags wrong");
    latch_needed_a: assert property (arr_go_o |-> $past(write_latch_o))
        else $error("cycle started without write latch");
    cycle_len_a: assert property ($fell(op_in_progress_o) |-> busy_cnt_q == want)
        else $error("busy length wrong");
    busy_no_start_a: assert property (op_in_progress_o && $past(op_in_progress_o) |-> !arr_go_o)
        else $error("start while busy");
    cs_before_go_a: assert property (arr_go_o |-> $past(cs_b_i, 3))
        else $error("start before select rose");
    chip_guard_a: assert property (arr_go_o && arr_cmd_o.op == SFPE_CHIP |->
        (!prot_i.cmp && prot_i.bp[2:0] == 3'h0) || (prot_i.cmp && prot_i.bp[2:0] == 3'h7))
        else $error("chip erase while protected");
    erase_align_a: assert property (arr_go_o |-> (arr_cmd_o.op != SFPE_SECT || arr_cmd_o.addr[11:0] == 12'h0)
        && (arr_cmd_o.op != SFPE_BLK64 || arr_cmd_o.addr[15:0] == 16'h0))
        else $error("erase target not aligned");
    cmd_on_go_a: assert property ($changed(arr_cmd_o) |-> arr_go_o)
        else $error("array command changed without start");
    rdparm_legal_a: assert property (rdparm_o.dummy inside {4'h4, 4'h6, 4'h8} &&
        rdparm_o.wrap_bytes inside {7'h08, 7'h10, 7'h20, 7'h40})
        else $error("read parameters illegal");
endmodule : sfpe_seq_chk

bind sfpe_flash_seq sfpe_seq_chk #(.TPP_CYC(TPP_CYC), .TSE_CYC(TSE_CYC), .TBE1_CYC(TBE1_CYC),
    .TBE2_CYC(TBE2_CYC), .TCE_CYC(TCE_CYC)) u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .ce_i(ce_i), .cs_b_i(cs_b_i), .prot_i(prot_i), .op_in_progress_o(op_in_progress_o),
    .write_latch_o(write_latch_o), .rdparm_o(rdparm_o), .arr_go_o(arr_go_o), .arr_cmd_o(arr_cmd_o));

/* File: tb/sfpe_host_model.sv */
`timescale 1ns/1ps
module sfpe_host_model (
    // serial link to the device
    output logic sclk_o,
    output logic cs_b_o,
    output logic [3:0] io_o
);
    logic [7:0] fb [0:299];
    initial begin
        sclk_o = 1'b0;
        cs_b_o = 1'b1;
        io_o = 4'h5;
    end
    // one clock pulse; unused lanes flip so stale values never look valid
    task automatic pulse(input logic [3:0] v, input bit q);
        io_o = q ? v : {~io_o[3:1], v[0]};
        #16 sclk_o = 1'b1;
        #16 sclk_o = 1'b0;
    endtask : pulse
    // whole frame with select low throughout; clock still outside frames
    task automatic send(input int n, input bit qo, input bit qr, input int xtra);
        cs_b_o = 1'b0;
        #8;
        for (int k = 0; k < n; k++) begin
            if (k == 0 ? qo : qr) begin
                pulse(fb[k][7:4], 1'b1);
                pulse(fb[k][3:0], 1'b1);
            end else begin
                for (int i = 7; i >= 0; i--) begin
                    pulse({3'h0, fb[k][i]}, 1'b0);
                end
            end
        end
        for (int i = 0; i < xtra; i++) begin
            pulse(4'(~i), qr);
        end
        #8 cs_b_o = 1'b1;
        io_o = ~io_o;
    endtask : send
endmodule : sfpe_host_model

/* File: tb/tb_sfpe_flash_seq.sv */
`timescale 1ns/1ps
module tb_sfpe_flash_seq import sfpe_pkg::*; ;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic four_lane_cmd_mode = 1'b0;
    logic qe = 1'b1;
    logic ce = 1'b1;
    sfpe_prot_t prot = '0;
    logic [7:0] pg_idx = 8'h0;
    logic sclk, cs_b, busy, latch, go, keep;
    logic [3:0] io;
    logic [7:0] pg_data;
    sfpe_rdparm_t rp;
    sfpe_arr_cmd_t cmd;
    int failures = 0;
    int check_count = 0;
    int go_cnt = 0;
    logic [23:0] a;
    logic [7:0] eop [0:2] = '{8'h20, 8'h52, 8'hd8};
    sfpe_op_t eki [0:2] = '{SFPE_SECT, SFPE_BLK32, SFPE_BLK64};
    logic [23:0] emsk [0:2] = '{24'h000fff, 24'h007fff, 24'h00ffff};
    // 2.5 ns half period gives the 200 MHz core clock
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (go) begin
            go_cnt++;
        end
    end
    sfpe_host_model host (.sclk_o(sclk), .cs_b_o(cs_b), .io_o(io));
    // long program time so the whole page can be read back while busy
    sfpe_flash_seq #(.TPP_CYC(32'h258), .TSE_CYC(32'h28), .TBE1_CYC(32'h30), .TBE2_CYC(32'h38),
        .TCE_CYC(32'h40)) uut (.core_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .sclk_i(sclk),
        .cs_b_i(cs_b), .io_i(io), .four_lane_cmd_mode_i(four_lane_cmd_mode), .four_lane_enable_i(qe), .prot_i(prot),
        .op_in_progress_o(busy), .write_latch_o(latch), .rdparm_o(rp), .arr_go_o(go), .arr_cmd_o(cmd),
        .pg_idx_i(pg_idx), .pg_data_o(pg_data), .pg_keep_o(keep));
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [3:0] dum(input logic [1:0] d);
        return (d == 2'h3) ? 4'h8 : (d == 2'h2) ? 4'h6 : 4'h4;
    endfunction : dum
    task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int n);
        host.fb[0] = op;
        {host.fb[1], host.fb[2], host.fb[3]} = ad;
        for (int i = 0; i < n; i++) begin
            host.fb[4 + i] = 8'($urandom);
        end
    endtask : frame
    // send, then the start pulse must come within the fixed latency or not at all
    task automatic run(input int n, input bit qr, input int xtra, input sfpe_op_t op, input logic [23:0] ad);
        int g;
        g = go_cnt;
        host.send(n, four_lane_cmd_mode, qr, xtra);
        repeat (12) @(negedge clk);
        chk(32'(go_cnt - g), (op != SFPE_NONE) ? 32'h1 : 32'h0);
        if (op != SFPE_NONE) begin
            chk(32'(cmd.op), 32'(op));
            chk({31'h0, latch}, 32'h0);
            chk({31'h0, busy}, 32'h1);
            if (op != SFPE_CHIP) begin
                chk({8'h0, cmd.addr}, {8'h0, ad});
            end
        end
    endtask : run
    task automatic unlock();
        host.fb[0] = 8'h06;
        host.send(1, four_lane_cmd_mode, four_lane_cmd_mode, 0);
        repeat (12) @(negedge clk);
        chk({31'h0, latch}, 32'h1);
    endtask : unlock
    task automatic idle();
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 900) begin
            @(negedge clk);
            t++;
        end
        chk({31'h0, busy}, 32'h0);
    endtask : idle
    // each buffer index holds the last byte sent to it, counted around the page
    task automatic chkpg(input logic [7:0] st, input int n);
        int m;
        for (int i = 0; i < 256; i++) begin
            @(negedge clk);
            pg_idx = 8'(i);
            @(negedge clk);
            m = (i - st) & 255;
            while (m + 256 < n) begin
                m += 256;
            end
            chk({31'h0, keep}, (m < n) ? 32'h1 : 32'h0);
            if (m < n) begin
                chk({24'h0, pg_data}, {24'h0, host.fb[4 + m]});
            end
        end
    endtask : chkpg
    initial begin
        a = 24'($urandom(45562));
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        chk({21'h0, rp}, {21'h0, 4'h4, 7'h08});
        chk({30'h0, busy, latch}, 32'h0);
        // short and overlong page programs, and one without unlock
        a = {1'b0, 23'($urandom)};
        unlock();
        frame(8'h02, a, 3);
        run(7, 1'b0, 0, SFPE_PAGE, a);
        chkpg(a[7:0], 3);
        idle();
        run(7, 1'b0, 0, SFPE_NONE, a);
        unlock();
        frame(8'h02, {a[23:8], 8'hf0}, 260);
        run(264, 1'b0, 0, SFPE_PAGE, {a[23:8], 8'hf0});
        chkpg(8'hf0, 260);
        idle();
        // four-lane program: no enable, half byte, then good
        @(negedge clk);
        qe = 1'b0;
        unlock();
        frame(8'h32, a, 2);
        run(6, 1'b1, 0, SFPE_NONE, a);
        @(negedge clk);
        qe = 1'b1;
        run(6, 1'b1, 1, SFPE_NONE, a);
        run(6, 1'b1, 0, SFPE_PAGE, a);
        // core enable low freezes the running cycle
        ce = 1'b0;
        repeat (20) @(negedge clk);
        ce = 1'b1;
        chk({31'h0, busy}, 32'h1);
        idle();
        // erases with a stray bit, then aligned
        for (int k = 0; k < 3; k++) begin
            unlock();
            frame(eop[k], a, 0);
            run(4, 1'b0, 1, SFPE_NONE, a);
            run(4, 1'b0, 0, eki[k], a & ~emsk[k]);
            idle();
        end
        // protected top 64KB refuses page program, sector erase, 64KB block erase and chip erase
        @(negedge clk);
        prot = {5'h01, 1'b0};
        unlock();
        frame(8'h02, 24'h7fff00, 1);
        run(5, 1'b0, 0, SFPE_NONE, a);
        frame(8'h20, 24'h7ff123, 0);
        run(4, 1'b0, 0, SFPE_NONE, a);
        frame(8'hd8, 24'h7f0000, 0);
        run(4, 1'b0, 0, SFPE_NONE, a);
        frame(8'h60, a, 0);
        run(1, 1'b0, 0, SFPE_NONE, a);
        frame(8'h20, 24'h001234, 0);
        run(4, 1'b0, 0, SFPE_SECT, 24'h001000);
        idle();
        @(negedge clk);
        prot = {5'h07, 1'b1};
        for (int k = 0; k < 2; k++) begin
            unlock();
            frame(k ? 8'hc7 : 8'h60, a, 0);
            run(1, 1'b0, 1, SFPE_NONE, a);
            run(1, 1'b0, 0, SFPE_CHIP, a);
            idle();
        end
        // parameter frame outside four-lane mode is ignored
        host.fb[0] = 8'hc0;
        host.fb[1] = 8'h3e;
        run(2, 1'b0, 0, SFPE_NONE, a);
        chk({21'h0, rp}, {21'h0, 4'h4, 7'h08});
        // read parameters in four-lane mode, every field code
        @(negedge clk);
        four_lane_cmd_mode = 1'b1;
        for (int k = 3; k >= 0; k--) begin
            host.fb[0] = 8'hc0;
            host.fb[1] = {2'($urandom), 2'(k), 2'($urandom), 2'(~k)};
            run(2, 1'b1, 0, SFPE_NONE, a);
            chk({21'h0, rp}, {21'h0, dum(2'(k)), 7'h08 << 2'(~k)});
        end
        @(negedge clk);
        four_lane_cmd_mode = 1'b0;
        repeat (4) @(negedge clk);
        four_lane_cmd_mode = 1'b1;
        repeat (4) @(negedge clk);
        chk({21'h0, rp}, {21'h0, 4'h4, 7'h40});
        end_sim();
    end
    // watchdog well past the expected run length
    initial begin
        #400000;
        failures++;
        end_sim();
    end
endmodule : tb_sfpe_flash_seq
